// ---- rtl/vff_pkg.sv ----
// Shared constants and types for the voice frame field generator.
// Assumes one clock domain and a frame sink on the same clock.
package vff_pkg;

  // Frame lengths in bits, one per supported frame kind
  localparam logic [11:0] LEN_SID  = 12'h030;  // Silence descriptor, 48 bits
  localparam logic [11:0] LEN_16K4 = 12'h148;  // 328 bits
  localparam logic [11:0] LEN_24K4 = 12'h1e8;  // 488 bits
  localparam logic [11:0] LEN_32K  = 12'h280;  // 640 bits
  localparam logic [11:0] LEN_48K  = 12'h3c0;  // 960 bits
  localparam logic [11:0] LEN_64K  = 12'h500;  // 1280 bits
  localparam logic [11:0] LEN_96K  = 12'h780;  // 1920 bits
  localparam logic [11:0] LEN_128K = 12'ha00;  // 2560 bits

  // Field widths
  localparam logic [4:0] BW_W        = 5'h02;  // Bandwidth code
  localparam logic [4:0] FLAG_W      = 5'h01;  // Any one-bit flag
  localparam logic [4:0] CT_W        = 5'h02;  // Coder type at 24.4, transform coder type at 24.4/32
  localparam logic [4:0] CT_LP16_W   = 5'h03;  // Coder type, linear prediction core at 16.4
  localparam logic [4:0] CT_TCX16_W  = 5'h04;  // Coder type, transform excitation core at 16.4
  localparam logic [4:0] CT_HQ16_W   = 5'h02;  // Coder type, high quality transform core at 16.4
  localparam logic [4:0] TCT_HI_W    = 5'h03;  // Transform coder type at 48/96/128
  localparam logic [4:0] JOINT_W     = 5'h08;  // Joint bandwidth and coder-type index
  localparam logic [4:0] SID_BW_W    = 5'h02;  // Silence descriptor bandwidth indicator
  localparam logic [4:0] SID_GAIN_W  = 5'h07;  // Silence descriptor global gain
  localparam logic [11:0] PAD_BITS   = 12'h003; // Trailing padding at 16.4 and 24.4
  localparam logic [11:0] NO_PAD     = 12'h000;

  // Header accumulator sizing
  localparam int unsigned HDR_W  = 16;
  localparam int unsigned HLEN_W = 5;

  // Frame kind derived from the frame length
  typedef enum logic [2:0]
  {
    RATE_SID  = 3'h0,
    RATE_16K4 = 3'h1,
    RATE_24K4 = 3'h2,
    RATE_32K  = 3'h3,
    RATE_48K  = 3'h4,
    RATE_64K  = 3'h5,
    RATE_96K  = 3'h6,
    RATE_128K = 3'h7
  } vff_rate_type;

  // One frame request from the user side
  typedef struct packed
  {
    logic [11:0] frameBits;    // Total frame length in bits
    logic        coreFamily;   // 0 linear prediction, 1 transform family
    logic        coreSelect;   // 0 transform excitation, 1 high quality transform
    logic [3:0]  coderType;    // Coder type, right aligned
    logic [1:0]  bandwidth;    // Bandwidth code
    logic [7:0]  jointIndex;   // Joint bandwidth and coder-type index
    logic        prevWasLp;    // Previous frame used linear prediction core
    logic        rate16k;      // Internal rate after linear prediction, 1 = 16 kHz
    logic        extPresent;   // Bandwidth extension in use
    logic        extSelect;    // 0 time-domain, 1 frequency-domain extension
    logic        reserved;     // Reserved flag value
    logic        noiseType;    // Silence descriptor noise type, 0 spectral
    logic        coreRate;     // Silence descriptor core sample-rate bit
    logic [6:0]  sidGain;      // Silence descriptor global gain
  } vff_req_type;

  // Serial bit towards the frame parser
  typedef struct packed
  {
    logic bitValue;
    logic bitValid;
    logic frameStart;
    logic frameEnd;
  } vff_bit_type;

endpackage

// ---- rtl/vff_len_table.sv ----
// Frame length to frame kind lookup.
// Assumes the length is stable while it is examined; purely combinational.
`timescale 1ns/1ps
module vff_len_table
(
  // Length in
  input  wire logic [11:0]          frameBits,
  // Kind out
  output vff_pkg::vff_rate_type     rateKind,
  output logic                      lenValid
);

  // Supported lengths in kind order
  localparam logic [11:0] LEN_TAB [8] = '{vff_pkg::LEN_SID, vff_pkg::LEN_16K4, vff_pkg::LEN_24K4,
                                          vff_pkg::LEN_32K, vff_pkg::LEN_48K, vff_pkg::LEN_64K,
                                          vff_pkg::LEN_96K, vff_pkg::LEN_128K};

  logic [7:0] hit;  // One match line per entry

  // One comparator per table entry
  for (genvar i = 0; i < 8; i++)
  begin : gMatch
    assign hit[i] = (frameBits == LEN_TAB[i]);
  end

  // Encode the match; at most one line can be high
  always_comb
  begin
    rateKind = vff_pkg::RATE_SID;
    for (int j = 0; j < 8; j++)
    begin
      if (hit[j])
      begin
        rateKind = vff_pkg::vff_rate_type'(j[2:0]);
      end
    end
    lenValid = |hit;
  end

endmodule

// ---- rtl/vff_hdr_shifter.sv ----
// Header shift register: loads a right-aligned header and
// emits it most significant bit first, one bit per shift.
// Assumes the loader does not load while bits remain.
`timescale 1ns/1ps
module vff_hdr_shifter
(
  // Clock and reset
  input  wire logic                          ref_clk,
  input  wire logic                          rst_b,
  // Load side
  input  wire logic                          load,
  input  wire logic [vff_pkg::HDR_W-1:0]     loadVec,
  input  wire logic [vff_pkg::HLEN_W-1:0]    loadLen,
  // Shift side
  input  wire logic                          shift,
  output logic                               headBit,
  output logic                               lastBit,
  output logic                               empty
);

  logic [vff_pkg::HDR_W-1:0]  vec_q;  // Header bits, right aligned
  logic [vff_pkg::HLEN_W-1:0] cnt_q;  // Bits still to go

  // Load wins over shift; one emitted bit per shift
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      vec_q <= '0;
      cnt_q <= '0;
    end
    else if (load)
    begin
      vec_q <= loadVec;
      cnt_q <= loadLen;
    end
    else if (shift && (cnt_q != '0))
    begin
      cnt_q <= cnt_q - 5'h01;
    end
  end

  // Topmost remaining bit goes first
  always_comb
  begin
    headBit = 1'b0;
    if (cnt_q != '0)
    begin
      headBit = vec_q[4'(cnt_q - 5'h01)];
    end
  end

  assign lastBit = (cnt_q == 5'h01);
  assign empty   = (cnt_q == '0);

endmodule

// ---- rtl/vff_frame_source.sv ----
// Voice frame source: builds coded frames bit by bit for a field parser.
// Assumes the parser and payload source share ref_clk; no pin crossing.
//
// Function
// [RULE_01] 16.4 kbps: 328 bits, bandwidth, reserved, padding
// [RULE_02] 16.4 coder type width follows core
// [RULE_03] 24.4 kbps: 488 bits with listed fields
// [RULE_04] One bit picks prediction or transform family
// [RULE_05] Next bit picks transform core
// [RULE_06] Excitation core adds two-bit coder type
// [RULE_07] Transform core: one or two switch bits
// [RULE_08] Second switch bit gives internal rate
// [RULE_09] 32 kbps: 640 bits, core-dependent field widths
// [RULE_10] 32/64 prediction frames use joint index
// [RULE_11] 32 kbps extension flag picks extension kind
// [RULE_12] 48 kbps: excitation core only, no family
// [RULE_13] 64 kbps: 1280 bits, prediction or transform
// [RULE_14] 96/128 kbps: 1920/2560 bits, excitation only
// [RULE_15] Silence descriptor is always 48 bits
// [RULE_16] Three silence descriptor variants supported
// [RULE_17] Spectral descriptor field order and widths
// [RULE_18] Every field goes most significant bit first
// [RULE_19] Noise-type flag picks descriptor variant
// [RULE_20] Bitrate from frame length; others rejected
// [RULE_21] Fields in order; padding sent as zero
`timescale 1ns/1ps
module vff_frame_source
(
  // Clock and reset
  input  wire logic                   ref_clk,
  input  wire logic                   rst_b,
  // Frame request
  input  wire vff_pkg::vff_req_type   req,
  input  wire logic                   reqValid,
  output logic                        reqReady,
  output logic                        reqError,
  // Payload bits from the core coder
  input  wire logic                   payBit,
  input  wire logic                   payValid,
  output logic                        payReady,
  // Serial frame towards the parser
  output vff_pkg::vff_bit_type        frameOut,
  output logic                        busy
);

  // Sequencer states
  typedef enum logic [3:0]
  {
    ST_IDLE = 4'h1,
    ST_HDR  = 4'h2,
    ST_PAY  = 4'h4,
    ST_PAD  = 4'h8
  } vff_state_type;

  vff_state_type state_q;               // Current phase of the frame
  vff_state_type state_d;

  vff_pkg::vff_rate_type rateKind;      // Kind derived from requested length
  logic                  lenValid;      // Requested length is supported

  logic [vff_pkg::HDR_W-1:0]  hdrVec;   // Assembled header, right aligned
  logic [vff_pkg::HLEN_W-1:0] hdrLen;   // Header length in bits
  logic [11:0]                padLen;   // Trailing padding length
  logic [11:0]                payLen;   // Payload bits between header and padding

  logic [11:0] payCnt_q;                // Payload bits left
  logic [11:0] padCnt_q;                // Padding bits left
  logic        hdrBit;                  // Next header bit
  logic        hdrLast;                 // Header is on its final bit
  logic        hdrEmpty;                // No header bits left
  logic        firstBit_q;              // Next bit opens the frame

  logic        accept;                  // Request taken this cycle
  logic        emit;                    // A frame bit leaves this cycle
  logic        emitValue;               // Value of that bit
  logic        emitLast;                // That bit closes the frame

  // Length lookup: the length alone tells the frame kind
  vff_len_table uLen
  (
    .frameBits (req.frameBits),
    .rateKind  (rateKind),
    .lenValid  (lenValid)
  );

  // Appends a field below what is already assembled, so the
  // earliest field stays on top and leaves first
  function automatic logic [20:0] push(input logic [20:0] acc, input logic [7:0] v, input logic [4:0] w);
    logic [15:0] vec;
    logic [4:0]  len;
    logic [15:0] mask;
    vec  = acc[20:5];
    len  = acc[4:0];
    mask = 16'((17'h00001 << w) - 17'h00001);
    vec  = 16'(vec << w) | ({8'h00, v} & mask);
    len  = 5'(len + w);
    return {vec, len};
  endfunction

  // Header assembly per frame kind, fields in transmit order
  always_comb
  begin
    logic [20:0] a;
    a      = '0;
    padLen = vff_pkg::NO_PAD;
    case (rateKind)
      vff_pkg::RATE_16K4:
      begin
        a = push(a, {6'h00, req.bandwidth}, vff_pkg::BW_W);                            // RULE_01
        a = push(a, {7'h00, req.reserved}, vff_pkg::FLAG_W);                           // RULE_01
        if (!req.coreFamily)
        begin
          a = push(a, {4'h0, req.coderType}, vff_pkg::CT_LP16_W);                      // RULE_02
        end
        else if (!req.coreSelect)
        begin
          a = push(a, {4'h0, req.coderType}, vff_pkg::CT_TCX16_W);                     // RULE_02
        end
        else
        begin
          a = push(a, {4'h0, req.coderType}, vff_pkg::CT_HQ16_W);                      // RULE_02
        end
        padLen = vff_pkg::PAD_BITS;                                                    // RULE_01
      end
      vff_pkg::RATE_24K4:
      begin
        a = push(a, {6'h00, req.bandwidth}, vff_pkg::BW_W);                            // RULE_03
        a = push(a, {7'h00, req.reserved}, vff_pkg::FLAG_W);                           // RULE_03
        a = push(a, {7'h00, req.coreFamily}, vff_pkg::FLAG_W);                         // RULE_04
        if (!req.coreFamily)
        begin
          a = push(a, {4'h0, req.coderType}, vff_pkg::CT_W);                           // RULE_03
        end
        else
        begin
          a = push(a, {7'h00, req.coreSelect}, vff_pkg::FLAG_W);                       // RULE_05
          if (!req.coreSelect)
          begin
            a = push(a, {4'h0, req.coderType}, vff_pkg::CT_W);                         // RULE_06
          end
          else
          begin
            a = push(a, {7'h00, req.prevWasLp}, vff_pkg::FLAG_W);                      // RULE_07
            if (req.prevWasLp)
            begin
              a = push(a, {7'h00, req.rate16k}, vff_pkg::FLAG_W);                      // RULE_08
            end
          end
        end
        padLen = vff_pkg::PAD_BITS;                                                    // RULE_03
      end
      vff_pkg::RATE_32K:
      begin
        a = push(a, {7'h00, req.coreFamily}, vff_pkg::FLAG_W);                         // RULE_04
        if (!req.coreFamily)
        begin
          // Four-bit bandwidth and four-bit coder type as one index
          a = push(a, req.jointIndex, vff_pkg::JOINT_W);                               // RULE_10
          if (req.extPresent)
          begin
            a = push(a, {7'h00, req.extSelect}, vff_pkg::FLAG_W);                      // RULE_11
          end
        end
        else
        begin
          a = push(a, {7'h00, req.coreSelect}, vff_pkg::FLAG_W);                       // RULE_05
          if (req.coreSelect)
          begin
            a = push(a, {7'h00, req.prevWasLp}, vff_pkg::FLAG_W);                      // RULE_07
            if (req.prevWasLp)
            begin
              a = push(a, {7'h00, req.rate16k}, vff_pkg::FLAG_W);                      // RULE_08
            end
          end
          a = push(a, {6'h00, req.bandwidth}, vff_pkg::BW_W);                          // RULE_09
          if (!req.coreSelect)
          begin
            a = push(a, {4'h0, req.coderType}, vff_pkg::CT_W);                         // RULE_09
          end
        end
      end
      vff_pkg::RATE_48K:
      begin
        // No family flag: the excitation core is implied
        a = push(a, {6'h00, req.bandwidth}, vff_pkg::BW_W);                            // RULE_12
        if (req.extPresent)
        begin
          a = push(a, {7'h00, req.reserved}, vff_pkg::FLAG_W);                         // RULE_12
        end
        a = push(a, {4'h0, req.coderType}, vff_pkg::TCT_HI_W);                         // RULE_12
      end
      vff_pkg::RATE_64K:
      begin
        a = push(a, {7'h00, req.coreFamily}, vff_pkg::FLAG_W);                         // RULE_13
        if (!req.coreFamily)
        begin
          a = push(a, req.jointIndex, vff_pkg::JOINT_W);                               // RULE_10
        end
        else
        begin
          a = push(a, {7'h00, req.prevWasLp}, vff_pkg::FLAG_W);                        // RULE_07
          if (req.prevWasLp)
          begin
            a = push(a, {7'h00, req.rate16k}, vff_pkg::FLAG_W);                        // RULE_08
          end
          a = push(a, {6'h00, req.bandwidth}, vff_pkg::BW_W);                          // RULE_13
        end
      end
      vff_pkg::RATE_96K,
      vff_pkg::RATE_128K:
      begin
        a = push(a, {6'h00, req.bandwidth}, vff_pkg::BW_W);                            // RULE_14
        a = push(a, {7'h00, req.reserved}, vff_pkg::FLAG_W);                           // RULE_14
        a = push(a, {4'h0, req.coderType}, vff_pkg::TCT_HI_W);                         // RULE_14
      end
      default:
      begin
        // Silence descriptor; the prediction variants carry their
        // remaining 47 bits as payload from the coder
        a = push(a, {7'h00, req.noiseType}, vff_pkg::FLAG_W);                          // RULE_19
        if (!req.noiseType)                                                            // RULE_16
        begin
          a = push(a, {6'h00, req.bandwidth}, vff_pkg::SID_BW_W);                      // RULE_17
          a = push(a, {7'h00, req.coreRate}, vff_pkg::FLAG_W);                         // RULE_17
          a = push(a, {1'b0, req.sidGain}, vff_pkg::SID_GAIN_W);                       // RULE_17
        end
      end
    endcase
    hdrVec = a[20:5];
    hdrLen = a[4:0];
  end

  // Payload fills whatever the header and padding leave; at 48 bits
  // this is 37 energy bits or 47 descriptor bits
  assign payLen = req.frameBits - {7'h00, hdrLen} - padLen;                           // RULE_15

  // A request is taken only when idle; an unsupported length is
  // refused and flagged instead of producing a frame
  assign reqReady = (state_q == ST_IDLE);
  assign accept   = reqValid && reqReady && lenValid;                                  // RULE_20

  // Header shift register
  vff_hdr_shifter uHdr
  (
    .ref_clk (ref_clk),
    .rst_b   (rst_b),
    .load    (accept),
    .loadVec (hdrVec),
    .loadLen (hdrLen),
    .shift   (state_q == ST_HDR),
    .headBit (hdrBit),
    .lastBit (hdrLast),
    .empty   (hdrEmpty)
  );

  // Payload is pulled only while its phase runs
  assign payReady = (state_q == ST_PAY);

  // Bit selection: header, then payload, then zero padding
  always_comb
  begin
    emit      = 1'b0;
    emitValue = 1'b0;
    emitLast  = 1'b0;
    state_d   = state_q;
    case (state_q)
      ST_IDLE:
      begin
        if (accept)
        begin
          state_d = ST_HDR;
        end
      end
      ST_HDR:
      begin
        emit      = !hdrEmpty;
        emitValue = hdrBit;                                                           // RULE_18
        if (hdrLast || hdrEmpty)
        begin
          // Payload of zero length goes straight on
          if (payCnt_q != 12'h000)
          begin
            state_d = ST_PAY;
          end
          else if (padCnt_q != 12'h000)
          begin
            state_d = ST_PAD;
          end
          else
          begin
            emitLast = 1'b1;
            state_d  = ST_IDLE;
          end
        end
      end
      ST_PAY:
      begin
        // A missing payload bit stalls the frame, it never inserts one
        emit      = payValid;
        emitValue = payBit;                                                           // RULE_21
        if (payValid && (payCnt_q == 12'h001))
        begin
          if (padCnt_q != 12'h000)
          begin
            state_d = ST_PAD;
          end
          else
          begin
            emitLast = 1'b1;
            state_d  = ST_IDLE;
          end
        end
      end
      ST_PAD:
      begin
        emit      = 1'b1;
        emitValue = 1'b0;                                                             // RULE_21
        if (padCnt_q == 12'h001)
        begin
          emitLast = 1'b1;
          state_d  = ST_IDLE;
        end
      end
      default:
      begin
        state_d = ST_IDLE;
      end
    endcase
  end

  // Phase register
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      state_q <= ST_IDLE;
    end
    else
    begin
      state_q <= state_d;
    end
  end

  // Payload and padding counters, loaded at acceptance
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      payCnt_q <= 12'h000;
      padCnt_q <= 12'h000;
    end
    else if (accept)
    begin
      payCnt_q <= payLen;
      padCnt_q <= padLen;
    end
    else
    begin
      if ((state_q == ST_PAY) && payValid && (payCnt_q != 12'h000))
      begin
        payCnt_q <= payCnt_q - 12'h001;
      end
      if ((state_q == ST_PAD) && (padCnt_q != 12'h000))
      begin
        padCnt_q <= padCnt_q - 12'h001;
      end
    end
  end

  // Marks the first emitted bit of each frame
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      firstBit_q <= 1'b0;
    end
    else if (accept)
    begin
      firstBit_q <= 1'b1;
    end
    else if (emit)
    begin
      firstBit_q <= 1'b0;
    end
  end

  // Registered serial output; one cycle behind the selection
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      frameOut <= '0;
    end
    else
    begin
      frameOut.bitValue   <= emit && emitValue;
      frameOut.bitValid   <= emit;
      frameOut.frameStart <= emit && firstBit_q;
      frameOut.frameEnd   <= emit && emitLast;
    end
  end

  // Refusal of an unsupported length, one pulse per refused request
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      reqError <= 1'b0;
    end
    else
    begin
      reqError <= reqValid && reqReady && !lenValid;                                   // RULE_20
    end
  end

  // Busy covers the whole frame, including the last output bit
  assign busy = (state_q != ST_IDLE) || frameOut.bitValid;

endmodule

// ---- bench/vff_frame_monitor.sv ----
// Port checker for the frame source.
// Assumes binding onto vff_frame_source, one clock domain.
`timescale 1ns/1ps
module vff_frame_monitor
(
  // Clock and reset
  input wire logic                 ref_clk,
  input wire logic                 rst_b,
  // Request side
  input wire vff_pkg::vff_req_type req,
  input wire logic                 reqValid,
  input wire logic                 reqReady,
  input wire logic                 reqError,
  // Payload and frame side
  input wire logic                 payBit,
  input wire logic                 payValid,
  input wire logic                 payReady,
  input wire vff_pkg::vff_bit_type frameOut,
  input wire logic                 busy
);
  logic        lenOk;     // Supported length
  logic        take;      // Accepted
  logic [11:0] pendLen_q; // Taken length
  logic [11:0] curLen_q;  // On-wire length
  logic [11:0] bitCnt_q;  // Bits so far
  assign lenOk = req.frameBits inside {vff_pkg::LEN_SID, vff_pkg::LEN_16K4, vff_pkg::LEN_24K4,
    vff_pkg::LEN_32K, vff_pkg::LEN_48K, vff_pkg::LEN_64K, vff_pkg::LEN_96K, vff_pkg::LEN_128K};
  assign take = reqValid && reqReady && lenOk;
  // Latch the length at frame start: the next request may be taken first
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      pendLen_q <= 12'h000;
      curLen_q  <= 12'h000;
      bitCnt_q  <= 12'h000;
    end
    else
    begin
      if (take)
        pendLen_q <= req.frameBits;
      if (frameOut.bitValid && frameOut.frameStart)
        curLen_q <= pendLen_q;
      if (frameOut.bitValid)
        bitCnt_q <= frameOut.frameStart ? 12'h001 : bitCnt_q + 12'h001;
    end
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  a_first_bit_time: assert property (take |-> ##2 frameOut.bitValid && frameOut.frameStart)
    else $error("first bit late");
  a_busy_accept: assert property (take |=> busy) else $error("no busy");
  a_bad_len_refused: assert property (reqValid && reqReady && !lenOk |=> reqError && !busy)
    else $error("not refused");
  a_busy_not_ready: assert property (busy && !frameOut.frameEnd |-> !reqReady) else $error("ready early");
  a_payload_echo: assert property (payValid && payReady |=>
    frameOut.bitValid && frameOut.bitValue == $past(payBit)) else $error("payload lost");
  a_pay_idle: assert property (!busy |-> !payReady) else $error("idle pay ready");
  a_start_shape: assert property (frameOut.frameStart |-> frameOut.bitValid && !frameOut.frameEnd)
    else $error("bad frame start");
  a_frame_length: assert property (frameOut.frameEnd |->
    frameOut.bitValid && bitCnt_q + 12'h001 == curLen_q) else $error("bad length");
  c_frame: cover property (take ##2 frameOut.frameStart);
  c_refuse: cover property (reqError);
  c_stall: cover property (payReady && !payValid ##1 payValid);
endmodule
bind vff_frame_source vff_frame_monitor u_mon (.*);

// ---- bench/vff_parser_model.sv ----
// Frame parser model: captures each serial frame MSB first.
// Assumes frameStart/frameEnd mark first and last bit.
`timescale 1ns/1ps
module vff_parser_model
(
  // Clock and reset
  input wire logic                 ref_clk,
  input wire logic                 rst_b,
  // Serial frame in
  input wire vff_pkg::vff_bit_type frameIn,
  // Captured frame
  output logic [0:2559]            capBits_q,
  output logic [11:0]              capCount_q,
  output logic                     capDone_q
);
  // Bits in arrival order
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      capBits_q  <= '0;
      capCount_q <= 12'h000;
      capDone_q  <= 1'b0;
    end
    else
    begin
      capDone_q <= frameIn.bitValid && frameIn.frameEnd;
      if (frameIn.bitValid)
      begin
        capBits_q[frameIn.frameStart ? 0 : capCount_q] <= frameIn.bitValue;
        capCount_q <= frameIn.frameStart ? 12'h001 : capCount_q + 12'h001;
      end
    end
  end
endmodule

// ---- bench/tb_top.sv ----
// Testbench: frame requests checked through the parser model.
// Assumes all-one payload, so padding shows as zeros.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin err_count++; \
  $display("ERROR %s exp %0h got %0h", nm, e, g); end end
module tb_top;
  logic                 ref_clk, rst_b, reqValid, payBit, payValid;
  logic                 reqReady, reqError, payReady, busy, capDone;
  vff_pkg::vff_req_type rq;
  vff_pkg::vff_bit_type frameOut;
  logic [0:2559]        capBits;
  logic [11:0]          capCount;
  int                   err_count, check_count;
  vff_frame_source DUT (.ref_clk, .rst_b, .req(rq), .reqValid, .reqReady, .reqError, .payBit, .payValid,
    .payReady, .frameOut, .busy);
  vff_parser_model u_sink (.ref_clk, .rst_b, .frameIn(frameOut), .capBits_q(capBits), .capCount_q(capCount),
    .capDone_q(capDone));
  initial
  begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end
  // Payload gaps every other cycle
  always @(negedge ref_clk) payValid <= ~payValid;
  task report_and_stop;
    $display("Checks %0d errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // Send rq; check length, header, first payload bit, padding
  task run(input logic [15:0] hdr, input int hlen);
    int pad, n;
    pad = (rq.frameBits == vff_pkg::LEN_16K4 || rq.frameBits == vff_pkg::LEN_24K4) ? 3 : 0;
    while (!reqReady) @(negedge ref_clk);
    reqValid = 1'b1;
    @(negedge ref_clk);
    reqValid = 1'b0;
    for (n = 0; !capDone && n < 8000; n++) @(negedge ref_clk);
    `CHK("length", rq.frameBits, capCount)
    for (int i = 0; i < hlen; i++) `CHK("header bit", hdr[hlen-1-i], capBits[i])
    `CHK("payload bit", 1'b1, capBits[hlen])
    for (int i = 0; i < pad; i++) `CHK("pad bit", 1'b0, capBits[rq.frameBits-1-i])
    $display("Test done, length %0d", rq.frameBits);
  endtask
  initial
  begin
    #1000000;
    err_count++;
    report_and_stop();
  end
  initial
  begin
    rst_b = 1'b0; reqValid = 1'b0; payValid = 1'b0; payBit = 1'b1; rq = '0;
    err_count = 0; check_count = 0;
    repeat (10) @(negedge ref_clk);
    `CHK("ready in reset", 1'b1, reqReady)
    rst_b = 1'b1;
    rq = '{frameBits:vff_pkg::LEN_SID, bandwidth:2'h2, coreRate:1'b1, sidGain:7'h55, default:'0};
    run(16'h02d5, 11);
    rq = '{frameBits:vff_pkg::LEN_SID, noiseType:1'b1, default:'0};
    run(16'h0001, 1);
    rq = '{frameBits:vff_pkg::LEN_16K4, bandwidth:2'h1, reserved:1'b1, coderType:4'h5, default:'0};
    run(16'h001d, 6);
    rq = '{frameBits:vff_pkg::LEN_16K4, bandwidth:2'h1, reserved:1'b1, coreFamily:1'b1, coderType:4'h9, default:'0};
    run(16'h0039, 7);
    rq = '{frameBits:vff_pkg::LEN_16K4, bandwidth:2'h1, reserved:1'b1, coreFamily:1'b1, coreSelect:1'b1,
      coderType:4'h2, default:'0};
    run(16'h000e, 5);
    rq = '{frameBits:vff_pkg::LEN_24K4, bandwidth:2'h3, coreFamily:1'b1, coreSelect:1'b1, prevWasLp:1'b1,
      rate16k:1'b1, default:'0};
    run(16'h006f, 7);
    rq = '{frameBits:vff_pkg::LEN_24K4, bandwidth:2'h2, reserved:1'b1, coreFamily:1'b1, coderType:4'h1, default:'0};
    run(16'h0059, 7);
    rq = '{frameBits:vff_pkg::LEN_24K4, bandwidth:2'h1, coderType:4'h2, default:'0};
    run(16'h0012, 6);
    rq = '{frameBits:vff_pkg::LEN_32K, jointIndex:8'ha5, extPresent:1'b1, extSelect:1'b1, default:'0};
    run(16'h014b, 10);
    rq = '{frameBits:vff_pkg::LEN_32K, coreFamily:1'b1, coreSelect:1'b1, bandwidth:2'h2, default:'0};
    run(16'h001a, 5);
    rq = '{frameBits:vff_pkg::LEN_32K, coreFamily:1'b1, bandwidth:2'h1, coderType:4'h3, default:'0};
    run(16'h0027, 6);
    rq = '{frameBits:vff_pkg::LEN_48K, bandwidth:2'h1, extPresent:1'b1, reserved:1'b1, coderType:4'h6, default:'0};
    run(16'h001e, 6);
    rq = '{frameBits:vff_pkg::LEN_48K, bandwidth:2'h2, coderType:4'h3, default:'0};
    run(16'h0013, 5);
    rq = '{frameBits:vff_pkg::LEN_64K, coreFamily:1'b1, prevWasLp:1'b1, bandwidth:2'h3, default:'0};
    run(16'h001b, 5);
    rq = '{frameBits:vff_pkg::LEN_64K, jointIndex:8'h3c, default:'0};
    run(16'h003c, 9);
    rq = '{frameBits:vff_pkg::LEN_96K, bandwidth:2'h2, reserved:1'b1, coderType:4'h3, default:'0};
    run(16'h002b, 6);
    rq.frameBits = vff_pkg::LEN_128K;
    run(16'h002b, 6);
    rq = '{frameBits:12'h100, default:'0};
    reqValid = 1'b1;
    @(negedge ref_clk);
    reqValid = 1'b0;
    `CHK("refuse flag", 1'b1, reqError)
    @(negedge ref_clk);
    `CHK("refuse pulse", 1'b0, reqError)
    `CHK("idle after refuse", 1'b0, busy)
    $display("Test done, refused length");
    report_and_stop();
  end
endmodule
